// ==== hw/lio_config.v ====
// Local programmable line and transmit power step configuration block.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "lio_defines.vh"

module lio_config #(
    parameter NUM_LINES  = `LIO_NUM_LINES,
    parameter NUM_SHARED = `LIO_NUM_SHARED
) (
    input  wire                   i_clk,
    input  wire                   i_reset_n,
    input  wire [`LIO_ADDR_W-1:0] i_addr,
    input  wire [7:0]             i_wdata,
    input  wire                   i_wr,
    input  wire                   i_rd,
    output wire [7:0]             o_rdata,
    input  wire [NUM_LINES-1:0]   i_line,
    output wire [NUM_LINES-1:0]   o_line,
    output wire [NUM_LINES-1:0]   o_line_oe_n,
    output wire [NUM_SHARED-1:0]  o_analog_en,
    output wire [1:0]             o_tx_step,
    output wire [7:0]             o_tx_dbm
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [7:0]           line_cfg_reg;
    reg  [7:0]           line_cfg_next;
    reg  [1:0]           tx_step_reg;
    reg  [1:0]           tx_step_next;
    reg  [NUM_LINES-1:0] line_out_reg;
    reg  [NUM_LINES-1:0] line_out_next;
    reg  [7:0]           rdata_reg;
    reg  [7:0]           rdata_next;
    reg  [7:0]           dbm_reg;
    reg  [NUM_LINES-1:0] pad_reg;

    wire [NUM_LINES-1:0] line_in;
    wire [NUM_LINES-1:0] drive_next;
    wire [NUM_LINES-1:0] oe_n;
    wire [NUM_LINES-1:0] dir_in;
    wire                 analog_sel;

    localparam [7:0] LINE_OUT_RESET = `LIO_LINE_OUT_RESET;
    localparam [7:0] TX_STEP_RESET  = `LIO_TX_STEP_RESET;

    // Maps a transmit step code to its output level in dBm.
    function [7:0] step_dbm;
        input [1:0] code;
        begin
            case (code)
                2'h0:    step_dbm = `LIO_DBM_STEP0;
                2'h1:    step_dbm = `LIO_DBM_STEP1;
                2'h2:    step_dbm = `LIO_DBM_STEP2;
                default: step_dbm = `LIO_DBM_STEP3;
            endcase
        end
    endfunction

    assign analog_sel = line_cfg_reg[`LIO_BIT_ANALOG];
    assign dir_in     = line_cfg_reg[`LIO_BIT_DIR_LSB +: NUM_LINES];

    // ------------------------------------------------------------------
    // Pads and input synchroniser
    // ------------------------------------------------------------------
    lio_pad_ctrl #(
        .NUM_LINES  (NUM_LINES),
        .NUM_SHARED (NUM_SHARED)
    ) u_pad (
        .i_dir_in     (dir_in),
        .i_analog_sel (analog_sel),
        .o_drive      (),
        .o_oe_n       (oe_n),
        .o_analog_en  (o_analog_en)
    );

    // The pad value register follows the configuration being written, so that a
    // line never shows a stale level in the cycle its direction changes.
    lio_pad_ctrl #(
        .NUM_LINES  (NUM_LINES),
        .NUM_SHARED (NUM_SHARED)
    ) u_pad_next (
        .i_dir_in     (line_cfg_next[`LIO_BIT_DIR_LSB +: NUM_LINES]),
        .i_analog_sel (line_cfg_next[`LIO_BIT_ANALOG]),
        .o_drive      (drive_next),
        .o_oe_n       (),
        .o_analog_en  ()
    );

    lio_sync #(
        .WIDTH (NUM_LINES)
    ) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   (i_line),
        .o_sync    (line_in)
    );

    // ------------------------------------------------------------------
    // Register writes and reads
    // ------------------------------------------------------------------
    always @* begin
        line_cfg_next = line_cfg_reg;
        tx_step_next  = tx_step_reg;
        line_out_next = line_out_reg;
        if (i_wr) begin
            case (i_addr)
                `LIO_OFS_LINE_CFG: begin
                    line_cfg_next = i_wdata;
                    line_cfg_next[`LIO_BIT_RESERVED] = 1'b0;
                end
                `LIO_OFS_TX_STEP: begin
                    // Values above the range are ignored.
                    if (i_wdata <= `LIO_STEP_MAX) begin
                        tx_step_next = i_wdata[1:0];
                    end
                end
                `LIO_OFS_LINE_OUT: begin
                    line_out_next = i_wdata[NUM_LINES-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always @* begin
        rdata_next = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `LIO_OFS_LINE_CFG: rdata_next = line_cfg_reg;
                `LIO_OFS_TX_STEP:  rdata_next = {6'h00, tx_step_reg};
                `LIO_OFS_LINE_IN:  rdata_next = {{(8-NUM_LINES){1'b0}}, line_in};
                `LIO_OFS_LINE_OUT: rdata_next = {{(8-NUM_LINES){1'b0}}, line_out_reg};
                `LIO_OFS_STATUS:   rdata_next = step_dbm(tx_step_reg);
                default:           rdata_next = 8'h00;
            endcase
        end
    end

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            line_cfg_reg <= `LIO_LINE_CFG_RESET;
            tx_step_reg  <= TX_STEP_RESET[1:0];
            line_out_reg <= LINE_OUT_RESET[NUM_LINES-1:0];
            rdata_reg    <= 8'h00;
            dbm_reg      <= `LIO_DBM_STEP3;
            pad_reg      <= {NUM_LINES{1'b0}};
        end else begin
            line_cfg_reg <= line_cfg_next;
            tx_step_reg  <= tx_step_next;
            line_out_reg <= line_out_next;
            rdata_reg    <= rdata_next;
            dbm_reg      <= step_dbm(tx_step_next);
            pad_reg      <= line_out_next & drive_next;
        end
    end

    assign o_rdata     = rdata_reg;
    assign o_line      = pad_reg;
    assign o_line_oe_n = oe_n;
    assign o_tx_step   = tx_step_reg;
    assign o_tx_dbm    = dbm_reg;

endmodule // lio_config

`default_nettype wire

// ==== hw/lio_defines.vh ====
// Constants for the local line and transmit level configuration block.
`ifndef LIO_DEFINES_VH
`define LIO_DEFINES_VH

`define LIO_ADDR_W            4
`define LIO_OFS_LINE_CFG      4'h0
`define LIO_OFS_TX_STEP       4'h1
`define LIO_OFS_LINE_IN       4'h2
`define LIO_OFS_LINE_OUT      4'h3
`define LIO_OFS_STATUS        4'h4

`define LIO_LINE_CFG_RESET    8'hc1
`define LIO_TX_STEP_RESET     8'h03
`define LIO_LINE_OUT_RESET    8'h00

`define LIO_BIT_ANALOG        0
`define LIO_BIT_RESERVED      1
`define LIO_BIT_DIR_LSB       2
`define LIO_NUM_LINES         6
`define LIO_NUM_SHARED        2

`define LIO_STEP_MAX          8'h03
`define LIO_DBM_STEP0         8'h14
`define LIO_DBM_STEP1         8'h17
`define LIO_DBM_STEP2         8'h1a
`define LIO_DBM_STEP3         8'h1b

`endif

// ==== hw/lio_pad_ctrl.v ====
// Per-line pad direction and analog steering.
`timescale 1ns/100ps
`default_nettype none

module lio_pad_ctrl #(
    parameter NUM_LINES  = 6,
    parameter NUM_SHARED = 2
) (
    input  wire [NUM_LINES-1:0] i_dir_in,
    input  wire                 i_analog_sel,
    output wire [NUM_LINES-1:0] o_drive,
    output wire [NUM_LINES-1:0] o_oe_n,
    output wire [NUM_SHARED-1:0] o_analog_en
);

    wire [NUM_LINES-1:0] shared_mask;

    // The top lines share pads with the analog inputs.
    assign shared_mask = {{NUM_SHARED{1'b1}}, {(NUM_LINES-NUM_SHARED){1'b0}}};

    // Output only when direction bit is zero and, for shared pads, analog off.
    assign o_drive     = ~i_dir_in & ~(shared_mask & {NUM_LINES{i_analog_sel}});
    assign o_oe_n      = ~o_drive;
    assign o_analog_en = {NUM_SHARED{i_analog_sel}};

endmodule // lio_pad_ctrl

`default_nettype wire

// ==== hw/lio_sync.v ====
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none

module lio_sync #(
    parameter WIDTH = 6
) (
    input  wire             i_clk,
    input  wire             i_reset_n,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    reg [WIDTH-1:0] out_reg;
    reg [WIDTH-1:0] out_next;

    integer k;

    // A line changes only once the second and third stages agree.
    always @* begin
        out_next = out_reg;
        for (k = 0; k < WIDTH; k = k + 1) begin
            if (s2_reg[k] == s3_reg[k]) begin
                out_next[k] = s3_reg[k];
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_reset_n) begin
            s1_reg  <= {WIDTH{1'b0}};
            s2_reg  <= {WIDTH{1'b0}};
            s3_reg  <= {WIDTH{1'b0}};
            out_reg <= {WIDTH{1'b0}};
        end else begin
            s1_reg  <= i_async;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign o_sync = out_reg;

endmodule // lio_sync

`default_nettype wire

// ==== verif/lio_config_asserts.sv ====
// Checker for the line and transmit level configuration block.
`timescale 1ns/100ps
`default_nettype none
module lio_config_chk #(parameter NUM_LINES = 6, parameter NUM_SHARED = 2) (
    input wire logic                  i_clk,
    input wire logic                  i_reset_n,
    input wire logic [3:0]            i_addr,
    input wire logic [7:0]            i_wdata,
    input wire logic                  i_wr,
    input wire logic                  i_rd,
    input wire logic [7:0]            o_rdata,
    input wire logic [NUM_LINES-1:0]  o_line,
    input wire logic [NUM_LINES-1:0]  o_line_oe_n,
    input wire logic [NUM_SHARED-1:0] o_analog_en,
    input wire logic [1:0]            o_tx_step,
    input wire logic [7:0]            o_tx_dbm
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire cfg_wr = i_wr && i_addr == 4'h0;
    wire tx_wr  = i_wr && i_addr == 4'h1;
    a_rsvd_reads_zero: assert property (i_rd && i_addr == 4'h0 |=> !o_rdata[1])
        else $error("reserved bit read back as one");
    a_prog_mode: assert property (cfg_wr && !i_wdata[0] |=> o_analog_en == 2'b00)
        else $error("shared pins left in analog use");
    a_analog_mode: assert property (cfg_wr && i_wdata[0] |=> o_analog_en == 2'b11)
        else $error("shared pins not given to analog use");
    a_low_dir: assert property (cfg_wr |=> o_line_oe_n[3:0] == $past(i_wdata[5:2]))
        else $error("line direction differs from written bits");
    a_shared_dir: assert property (cfg_wr |=> o_line_oe_n[5:4] ==
        ($past(i_wdata[7:6]) | {2{$past(i_wdata[0])}})) else $error("shared line direction wrong");
    a_analog_no_drv: assert property (o_analog_en[0] |-> o_line_oe_n[5:4] == 2'b11)
        else $error("shared line driven in analog use");
    a_line_gated: assert property ((o_line & o_line_oe_n) == '0)
        else $error("line value shown while not driving");
    a_tx_step_take: assert property (tx_wr && i_wdata <= 8'h03 |=> o_tx_step == $past(i_wdata[1:0]))
        else $error("transmit step not taken");
    a_tx_refused: assert property (tx_wr && i_wdata > 8'h03 |=> $stable(o_tx_step))
        else $error("out of range step accepted");
    a_tx_dbm_map: assert property (o_tx_dbm == (o_tx_step == 2'd0 ? 8'h14 : o_tx_step == 2'd1 ? 8'h17 :
        o_tx_step == 2'd2 ? 8'h1a : 8'h1b)) else $error("power level does not match step");
    a_reset_load: assert property ($rose(i_reset_n) |-> o_tx_step == 2'd3 && o_line_oe_n == 6'h30 && o_analog_en == 2'b11)
        else $error("reset values not loaded");
    cover property (cfg_wr && i_wdata[0]);
    cover property (tx_wr && i_wdata > 8'h03);
    cover property (i_rd && i_addr == 4'h0);
endmodule // lio_config_chk

bind lio_config lio_config_chk #(.NUM_LINES(NUM_LINES), .NUM_SHARED(NUM_SHARED)) u_chk (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_line(o_line), .o_line_oe_n(o_line_oe_n),
    .o_analog_en(o_analog_en),
    .o_tx_step(o_tx_step), .o_tx_dbm(o_tx_dbm));
`default_nettype wire

// ==== verif/lio_config_test.sv ====
// Self-checking bench for the line and transmit level configuration block.
`timescale 1ns/100ps
`default_nettype none
module lio_config_test;
    logic       i_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0;
    logic [3:0] i_addr = 0;
    logic [7:0] i_wdata = 0, o_rdata, o_tx_dbm;
    logic [5:0] i_line = 0, o_line, o_line_oe_n;
    logic [1:0] o_analog_en, o_tx_step;
    int         err_count = 0, samples_checked = 0, cfg_m, tx_m, out_m, d;
    always #12.5 i_clk = ~i_clk;
    lio_config u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_line(i_line), .o_line(o_line),
        .o_line_oe_n(o_line_oe_n), .o_analog_en(o_analog_en), .o_tx_step(o_tx_step),
        .o_tx_dbm(o_tx_dbm));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] dbm(input int s);
        return s == 0 ? 20 : s == 1 ? 23 : s == 2 ? 26 : 27;
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", e, o_rdata);
    endtask
    task automatic ports;
        logic [5:0] oe;
        oe = cfg_m[7:2] | {cfg_m[0], cfg_m[0], 4'h0};
        chk("oe_n", {2'b00, oe}, {2'b00, o_line_oe_n});
        chk("analog_en", {6'h00, {2{cfg_m[0]}}}, {6'h00, o_analog_en});
        chk("tx_step", tx_m[7:0], {6'h00, o_tx_step});
        chk("tx_dbm", dbm(tx_m), o_tx_dbm);
        chk("line", {2'b00, out_m[5:0] & ~oe}, {2'b00, o_line});
    endtask
    task automatic do_reset;
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        cfg_m = 193;
        tx_m = 3;
        out_m = 0;
        ports;
        rd(4'h0, 8'hc1);
        rd(4'h1, 8'h03);
    endtask
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4000) @(posedge i_clk);
        err_count++;
        conclude;
    end
    initial begin
        d = $urandom(45);
        do_reset;
        $display("test reset done");
        for (int c = 0; c < 10; c++) begin
            d = c < 8 ? c : $urandom % 256;
            wr(4'h1, d[7:0]);
            if (d < 4) tx_m = d;
            ports;
            rd(4'h1, tx_m[7:0]);
            rd(4'h4, dbm(tx_m));
        end
        $display("test transmit step done");
        for (int k = 0; k < 24; k++) begin
            d = k < 2 ? k : $urandom;
            wr(4'h0, d[7:0]);
            cfg_m = d & 8'hfd;
            wr(4'h3, d[15:8]);
            out_m = d[13:8];
            ports;
            rd(4'h0, cfg_m[7:0]);
            rd(4'h3, out_m[7:0]);
        end
        $display("test line config done");
        @(posedge i_clk);
        i_line <= d[21:16];
        repeat (6) @(posedge i_clk);
        rd(4'h2, {2'b00, d[21:16]});
        wr(4'hf, 8'h5a);
        rd(4'hf, 8'h00);
        ports;
        do_reset;
        $display("test unmapped and reset done");
        conclude;
    end
endmodule // lio_config_test
`default_nettype wire
